//--- spi_fmt_pkg.sv
// Constants shared by the serial port, the far end and the testbench.
// Assumes one bus clock of 250 MHz for both ends of the link.
package spi_fmt_pkg;
  // ==========================================================
  // Register map (index times four gives the APB byte address)
  localparam int         ADDR_W    = 10;
  localparam logic [7:0] CTRL_IDX  = 8'h10;
  localparam logic [7:0] STAT_IDX  = 8'h11;
  localparam logic [7:0] DATA_IDX  = 8'h12;
  localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [9:0] STAT_ADDR = {STAT_IDX, 2'b00};
  localparam logic [9:0] DATA_ADDR = {DATA_IDX, 2'b00};
  // ==========================================================
  // Control register fields
  localparam int         CTRL_CLOCK_POLARITY_BIT = 0;
  localparam int         CTRL_CLOCK_PHASE_BIT = 1;
  localparam int         CTRL_EN   = 2;
  localparam int         CTRL_MSTR = 3;
  localparam int         CTRL_RATE = 4;
  localparam int         CTRL_SELB = 6;
  localparam logic [7:0] CTRL_RST  = 8'h40;
  // ==========================================================
  // Status register fields
  localparam int         STAT_RXFULL  = 0;
  localparam int         STAT_TXEMPTY = 1;
  localparam int         STAT_BUSY    = 2;
  // ==========================================================
  // Framing and rate constants
  localparam logic [3:0] LAST_STEP   = 4'hF;
  localparam logic [3:0] CPHA1_LAST  = 4'hE;
  localparam logic [5:0] HALF_DIV2   = 6'h00;
  localparam logic [5:0] HALF_DIV8   = 6'h03;
  localparam logic [5:0] HALF_DIV32  = 6'h0F;
  localparam logic [5:0] HALF_DIV128 = 6'h3F;
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam int         SYNC_W      = 3;
endpackage : spi_fmt_pkg

//--- spi_link_if.sv
// Serial link between the port and its far end.
// Assumes the bench watches the resolved lines, enables and selects; undriven lines read high.
`timescale 1ns/1ps
interface spi_link_if;
  logic devSclk, devSclkOeB, parSclk, parSclkOeB;
  logic devMosi, devMosiOeB, parMosi, parMosiOeB;
  logic devMiso, devMisoOeB, parMiso, parMisoOeB;
  logic devSelB;
  logic parSelB;
  wire  sclk;
  wire  mosi;
  wire  miso;
  // ==========================================================
  // Wire resolution from the low-active enables
  assign sclk = !devSclkOeB ? devSclk : (!parSclkOeB ? parSclk : 1'b1);
  assign mosi = !devMosiOeB ? devMosi : (!parMosiOeB ? parMosi : 1'b1);
  assign miso = !devMisoOeB ? devMiso : (!parMisoOeB ? parMiso : 1'b1);
  modport dev (output devSclk, devSclkOeB, devMosi, devMosiOeB,
               output devMiso, devMisoOeB, devSelB,
               input  sclk, mosi, miso, parSelB);
  modport par (output parSclk, parSclkOeB, parMosi, parMosiOeB,
               output parMiso, parMisoOeB, parSelB,
               input  sclk, mosi, miso, devSelB);
endinterface : spi_link_if

//--- spi_far_end.sv
// Far end of the link: a master or slave peer driven by plain user ports.
// Assumes startReq is a one-cycle pulse while busy is low.
`timescale 1ns/1ps
module spi_far_end #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  spi_link_if.par               link,
  input  wire logic             master,
  input  wire logic             clock_polarity_bit,
  input  wire logic             clock_phase_bit,
  input  wire logic             selHold,
  input  wire logic [DIV_W-1:0] halfLim,
  input  wire logic             startReq,
  input  wire logic [7:0]       txByte,
  output logic      [7:0]       rxByte,
  output logic                  rxValid,
  output logic                  busy
);
  import spi_fmt_pkg::*;
  typedef enum logic [1:0] {P_IDLE, P_SETUP, P_SHIFT, P_HOLD} far_state_type;

  if (DIV_W < 1) begin : g_chk
    $error("DIV_W must be at least 1");
  end

  far_state_type      state_ff;
  logic [DIV_W-1:0]   cnt_ff;
  logic [3:0]         step_ff;
  logic [7:0]         shift_ff;
  logic [7:0]         rx_ff;
  logic               inBit_ff, valid_ff, selB_ff, sclk_ff, oeB_ff;
  logic [SYNC_W-1:0]  sclkS_ff, ssS_ff;
  logic [1:0]         mosiS_ff, misoS_ff;

  // ==========================================================
  // Decode
  wire tick    = (state_ff != P_IDLE) && master && (cnt_ff == halfLim);
  wire sEdge   = sclkS_ff[1] ^ sclkS_ff[2];
  wire ssLow   = !ssS_ff[1];
  wire ssFall  = ssS_ff[2] & !ssS_ff[1];
  wire serIn   = master ? misoS_ff[1] : mosiS_ff[1];
  wire idle    = (state_ff == P_IDLE);
  wire sStart  = !master && idle && ((!clock_phase_bit && ssFall) ||
                 (clock_phase_bit && ssLow && sEdge));
  wire sAdv    = !master && (state_ff == P_SHIFT) && ssLow && sEdge;
  wire mAdv    = master && (state_ff == P_SHIFT) && tick;
  wire adv     = mAdv || sAdv;
  wire lastAdv = (!master && clock_phase_bit) ? (step_ff == CPHA1_LAST)
                                   : (step_ff == LAST_STEP);
  wire finBit  = (!master && clock_phase_bit) ? serIn : inBit_ff;
  wire done    = adv && lastAdv;
  wire [3:0] nxtStep = step_ff + 4'h1;
  wire keepSel = clock_phase_bit && selHold;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkS_ff <= '0;
      ssS_ff   <= '1;
      mosiS_ff <= '0;
      misoS_ff <= '0;
    end else if (ce) begin
      sclkS_ff <= {sclkS_ff[1:0], link.sclk};
      ssS_ff   <= {ssS_ff[1:0], link.devSelB};
      mosiS_ff <= {mosiS_ff[0], link.mosi};
      misoS_ff <= {misoS_ff[0], link.miso};
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= P_IDLE;
      cnt_ff   <= '0;
      step_ff  <= 4'h0;
      shift_ff <= BYTE_RST;
      inBit_ff <= 1'b0;
      selB_ff  <= 1'b1;
    end else if (ce) begin
      cnt_ff <= (idle || tick) ? '0 : cnt_ff + DIV_W'(1);
      unique case (state_ff)
        P_IDLE: begin
          if (master && startReq) begin
            state_ff <= P_SETUP;
            shift_ff <= txByte;
            selB_ff  <= 1'b0;
          end else if (sStart) begin
            state_ff <= P_SHIFT;
            step_ff  <= 4'h0;
          end else if (!master && startReq) begin
            shift_ff <= txByte;
          end
        end
        P_SETUP: begin
          if (tick) begin
            state_ff <= P_SHIFT;
            step_ff  <= 4'h0;
          end
        end
        P_SHIFT: begin
          if (!master && !ssLow) begin
            state_ff <= P_IDLE;
          end else if (done) begin
            state_ff <= master ? P_HOLD : P_IDLE;
          end else if (adv) begin
            step_ff <= nxtStep;
            if (nxtStep[0]) begin
              inBit_ff <= serIn;
            end else begin
              shift_ff <= {shift_ff[6:0], inBit_ff};
            end
          end
        end
        P_HOLD: begin
          if (tick) begin
            state_ff <= P_IDLE;
            selB_ff  <= !keepSel;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  wire nxtSclk = clock_polarity_bit ^ (master && (state_ff == P_SHIFT) &&
                 (step_ff[0] ^ clock_phase_bit));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_ff    <= BYTE_RST;
      valid_ff <= 1'b0;
      sclk_ff  <= 1'b0;
      oeB_ff   <= 1'b1;
    end else if (ce) begin
      valid_ff <= done;
      if (done) begin
        rx_ff <= {shift_ff[6:0], finBit};
      end
      sclk_ff <= nxtSclk;
      oeB_ff  <= !(!master && ssLow);
    end
  end

  assign link.parSclk    = sclk_ff;
  assign link.parSclkOeB = !master;
  assign link.parMosi    = shift_ff[7];
  assign link.parMosiOeB = !master;
  assign link.parMiso    = shift_ff[7];
  assign link.parMisoOeB = oeB_ff;
  assign link.parSelB    = selB_ff;
  assign rxByte          = rx_ff;
  assign rxValid         = valid_ff;
  assign busy            = !idle;
endmodule : spi_far_end

//--- spi_port_dev.sv
// Serial port core: polarity/phase formats, master and slave start rules.
// Assumes an APB master on the bus side and spi_link_if on the pin side.
//
// Contract
// - Polarity bit sets clock idle level only
// - Phase bit picks one of two formats
// - Both ends share polarity and phase
// - Software disables port before format change
// - Slave drives data out only when selected
// - Master keeps own select input high
// - Phase zero: first edge captures MSB
// - Phase zero: select toggles between bytes
// - Phase zero slave starts on select fall
// - No shift reload during slave transfer
// - Slave writes data before transfer start
// - Phase one: first clock edge starts transfer
// - Phase one: select may stay low
// - Phase one slave starts on first edge
// - Master data write starts a transfer
// - Start delay independent of phase (phase zero: first sclk edge comes half a bit later)
// - Master clock free-runs, gated by enable
// - Master clock edges on bus clock
// - Write-to-start delay at most one bit
// - Master bit chooses master or slave
// - Late slave write resends old byte
`timescale 1ns/1ps
module spi_port_dev (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      ce,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [spi_fmt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  spi_link_if.dev                        link
);
  import spi_fmt_pkg::*;
  typedef enum logic {IDLE, SHIFT} xfer_state_type;

  xfer_state_type    state_ff;
  logic [7:0]        ctrl_ff, txBuf_ff, shift_ff, rxData_ff;
  logic              txFull_ff, rxFull_ff, inBit_ff, sclk_ff, misoOeB_ff;
  logic [3:0]        step_ff;
  logic [5:0]        divCnt_ff;
  logic [SYNC_W-1:0] sclkS_ff, ssS_ff;
  logic [1:0]        mosiS_ff, misoS_ff;

  // ==========================================================
  // Control decode
  wire       clock_polarity_bit    = ctrl_ff[CTRL_CLOCK_POLARITY_BIT];
  wire       clock_phase_bit    = ctrl_ff[CTRL_CLOCK_PHASE_BIT];
  wire       en      = ctrl_ff[CTRL_EN];
  wire       mstr    = ctrl_ff[CTRL_MSTR];
  wire [1:0] rate    = ctrl_ff[CTRL_RATE +: 2];
  wire [5:0] halfLim = (rate == 2'b00) ? HALF_DIV2  :
                       (rate == 2'b01) ? HALF_DIV8  :
                       (rate == 2'b10) ? HALF_DIV32 : HALF_DIV128;
  wire       runClk  = en && mstr;
  wire       slvMode = en && !mstr;
  wire       tick    = runClk && (divCnt_ff == halfLim);

  // ==========================================================
  // APB decode
  wire access  = psel && penable;
  wire hitCtrl = (paddr == CTRL_ADDR);
  wire hitStat = (paddr == STAT_ADDR);
  wire hitData = (paddr == DATA_ADDR);
  wire hitAny  = hitCtrl || hitStat || hitData;
  wire ctrlWr  = access && pwrite && hitCtrl;
  wire dataWr  = access && pwrite && hitData;
  wire dataRd  = access && !pwrite && hitData;
  wire busy    = (state_ff == SHIFT);
  wire [7:0] status = {5'h00, busy, !txFull_ff, rxFull_ff};

  assign pready  = 1'b1;
  assign pslverr = access && !hitAny;
  assign prdata  = hitCtrl ? {24'h000000, ctrl_ff}   :
                   hitStat ? {24'h000000, status}    :
                   hitData ? {24'h000000, rxData_ff} : 32'h00000000;

  // ==========================================================
  // Transfer decode
  wire sEdge   = sclkS_ff[1] ^ sclkS_ff[2];
  wire ssLow   = !ssS_ff[1];
  wire ssFall  = ssS_ff[2] && !ssS_ff[1];
  wire serIn   = mstr ? misoS_ff[1] : mosiS_ff[1];
  wire slvBeg0 = !clock_phase_bit && ssFall;
  wire slvBeg1 = clock_phase_bit && ssLow && sEdge;
  wire sStart  = slvMode && !busy && (slvBeg0 || slvBeg1);
  wire mStart  = runClk && !busy && txFull_ff && tick;
  wire start   = mStart || sStart;
  wire sAdv    = slvMode && busy && ssLow && sEdge;
  wire mAdv    = runClk && busy && tick;
  wire adv     = mAdv || sAdv;
  wire sAbort  = slvMode && busy && !ssLow;
  wire lastAdv = (!mstr && clock_phase_bit) ? (step_ff == CPHA1_LAST)
                                 : (step_ff == LAST_STEP);
  wire finBit  = (!mstr && clock_phase_bit) ? serIn : inBit_ff;
  wire done    = adv && lastAdv;
  wire idleLd  = slvMode && !busy && !sStart && txFull_ff;
  wire load    = (start || idleLd) && txFull_ff;
  wire [3:0] nxtStep = step_ff + 4'h1;

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff   <= CTRL_RST;
      txBuf_ff  <= BYTE_RST;
      txFull_ff <= 1'b0;
      rxFull_ff <= 1'b0;
      rxData_ff <= BYTE_RST;
    end else if (ce) begin
      if (ctrlWr) begin
        ctrl_ff <= pwdata[7:0];
      end
      if (dataWr) begin
        txBuf_ff <= pwdata[7:0];
      end
      txFull_ff <= dataWr || (txFull_ff && !load);
      rxFull_ff <= done || (rxFull_ff && !dataRd);
      if (done) begin
        rxData_ff <= {shift_ff[6:0], finBit};
      end
    end
  end

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkS_ff <= '0;
      ssS_ff   <= '1;
      mosiS_ff <= '0;
      misoS_ff <= '0;
    end else if (ce) begin
      sclkS_ff <= {sclkS_ff[1:0], link.sclk};
      ssS_ff   <= {ssS_ff[1:0], link.parSelB};
      mosiS_ff <= {mosiS_ff[0], link.mosi};
      misoS_ff <= {misoS_ff[0], link.miso};
    end
  end

  // ==========================================================
  // Free-running master divider
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_ff <= 6'h00;
    end else if (ce) begin
      divCnt_ff <= (!runClk || tick) ? 6'h00 : divCnt_ff + 6'h01;
    end
  end

  // ==========================================================
  // Shift engine; odd steps capture, even steps shift
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= IDLE;
      step_ff  <= 4'h0;
      shift_ff <= BYTE_RST;
      inBit_ff <= 1'b0;
    end else if (ce) begin
      if (!en || sAbort || done) begin
        state_ff <= IDLE;
      end else if (start) begin
        state_ff <= SHIFT;
        step_ff  <= 4'h0;
        if (txFull_ff) begin
          shift_ff <= txBuf_ff;
        end
      end else if (adv) begin
        step_ff <= nxtStep;
        if (nxtStep[0]) begin
          inBit_ff <= serIn;
        end else begin
          shift_ff <= {shift_ff[6:0], inBit_ff};
        end
      end else if (idleLd) begin
        shift_ff <= txBuf_ff;
      end
    end
  end

  // ==========================================================
  // Pin drive
  wire nxtSclk = clock_polarity_bit ^ (runClk && busy && (step_ff[0] ^ clock_phase_bit));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_ff    <= 1'b0;
      misoOeB_ff <= 1'b1;
    end else if (ce) begin
      sclk_ff    <= nxtSclk;
      misoOeB_ff <= !(slvMode && ssLow);
    end
  end

  assign link.devSclk    = sclk_ff;
  assign link.devSclkOeB = !runClk;
  assign link.devMosi    = shift_ff[7];
  assign link.devMosiOeB = !runClk;
  assign link.devMiso    = shift_ff[7];
  assign link.devMisoOeB = misoOeB_ff;
  assign link.devSelB    = ctrl_ff[CTRL_SELB];
endmodule : spi_port_dev

//--- spi_link_props.sv
// Checker on the serial link between the port and its far end.
// Assumes both ends share clk and rst_b; sees link signals only.
`timescale 1ns/1ps
module spi_link_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic devSclkOeB,
  input wire logic parSclkOeB,
  input wire logic devMosiOeB,
  input wire logic parMosiOeB,
  input wire logic devMisoOeB,
  input wire logic parMisoOeB,
  input wire logic devSelB,
  input wire logic parSelB,
  input wire logic sclk
);
  // ==========================================================
  // Clock edges seen inside one device select frame
  logic       sclkQ_ff;
  logic [5:0] edgeCnt_ff;
  logic [5:0] nxt_edgeCnt;
  assign nxt_edgeCnt = devSelB ? 6'h00
                     : edgeCnt_ff + {5'h00, sclk != sclkQ_ff};
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkQ_ff   <= 1'b1;
      edgeCnt_ff <= 6'h00;
    end else begin
      sclkQ_ff   <= sclk;
      edgeCnt_ff <= nxt_edgeCnt;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence selFallSlave;
    $fell(parSelB) && devSclkOeB;
  endsequence
  sel_release_a: assert property (parSelB [*6] |-> devMisoOeB)
    else $error("port drives miso while deselected");
  slave_start_a: assert property (selFallSlave |-> ##[1:6] !devMisoOeB)
    else $error("slave miso not driven after select fall");
  far_release_a: assert property (devSelB [*6] |-> parMisoOeB)
    else $error("far end drives miso while deselected");
  one_clk_a: assert property (devSclkOeB || parSclkOeB)
    else $error("two drivers on sclk");
  one_mosi_a: assert property (devMosiOeB || parMosiOeB)
    else $error("two drivers on mosi");
  one_miso_a: assert property (devMisoOeB || parMisoOeB)
    else $error("two drivers on miso");
  slave_no_clk_a: assert property (!devMisoOeB |-> devSclkOeB)
    else $error("slave port drives sclk");
  frame_edges_a: assert property ($rose(devSelB) && !devSclkOeB
    |-> edgeCnt_ff == 6'h10) else $error("frame edge count not sixteen");
endmodule : spi_link_props

//--- spi_transfer_format_timing_tb.sv
// Testbench: port and far end joined, driven over APB and user ports.
// Assumes the far end mirrors the port's polarity and phase.
`timescale 1ns/1ps
module spi_transfer_format_timing_tb;
  import spi_fmt_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        feMaster, feCpol, feCpha, feSelHold, feStart;
  logic        feValid, feBusy, e;
  logic [7:0]  feHalf, feTx, feRx, feGot, cfg;
  logic [1:0]  rate;
  int          fails, nCompared, bitT, cnt;
  logic [7:0]  farBytes [4] = '{8'hC3, 8'h5A, 8'h81, 8'h7E};
  logic [7:0]  devBytes [4] = '{8'h96, 8'h3C, 8'hE1, 8'h18};
  spi_link_if spi_link_if_i ();
  spi_port_dev spi_port_dev_i (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(spi_link_if_i));
  spi_far_end spi_far_end_i (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .link(spi_link_if_i), .master(feMaster), .clock_polarity_bit(feCpol),
    .clock_phase_bit(feCpha), .selHold(feSelHold), .halfLim(feHalf),
    .startReq(feStart), .txByte(feTx), .rxByte(feRx),
    .rxValid(feValid), .busy(feBusy));
  spi_link_props spi_link_props_i (.clk(clk), .rst_b(rst_b),
    .devSclkOeB(spi_link_if_i.devSclkOeB),
    .parSclkOeB(spi_link_if_i.parSclkOeB),
    .devMosiOeB(spi_link_if_i.devMosiOeB),
    .parMosiOeB(spi_link_if_i.parMosiOeB),
    .devMisoOeB(spi_link_if_i.devMisoOeB),
    .parMisoOeB(spi_link_if_i.parMisoOeB),
    .devSelB(spi_link_if_i.devSelB), .parSelB(spi_link_if_i.parSelB),
    .sclk(spi_link_if_i.sclk));
  // ==========================================================
  // Clock, watchdog and far end capture
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    $display("[FAIL] watchdog expected finish seen hang");
    report_and_stop;
  end
  always @(posedge clk) if (feValid === 1'b1) feGot <= feRx;
  // ==========================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] x, y);
    nCompared++;
    if (y !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, x, y);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask : wr
  task automatic rdChk(input string n, input logic [9:0] a,
                       input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, r);
  endtask : rdChk
  task automatic waitRx;
    r = 32'h0;
    for (int i = 0; i < 600 && r[STAT_RXFULL] !== 1'b1; i++)
      apb(1'b0, STAT_ADDR, 32'h0);
    if (r[STAT_RXFULL] !== 1'b1) begin
      fails++;
      $display("[FAIL] rx wait expected 1 seen %b", r[STAT_RXFULL]);
    end
  endtask : waitRx
  task automatic feGo(input logic [7:0] b);
    feTx <= b;
    feStart <= 1'b1;
    @(posedge clk);
    feStart <= 1'b0;
    @(posedge clk);
  endtask : feGo
  task automatic waitFe;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 2000 && feBusy !== 1'b0; i++) @(posedge clk);
    if (feBusy !== 1'b0) begin
      fails++;
      $display("[FAIL] far wait expected 0 seen %b", feBusy);
    end
    repeat (2) @(posedge clk);
  endtask : waitFe
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Tests
  initial begin
    {rst_b, psel, penable, pwrite, feMaster, feCpol, feCpha} = 7'h00;
    {feSelHold, feStart, paddr, pwdata, feTx} = '0;
    feHalf = 8'h07;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdChk("ctrl reset", CTRL_ADDR, {24'h000000, CTRL_RST});
    rdChk("stat reset", STAT_ADDR, 32'h2);
    apb(1'b0, 10'h3FC, 32'h0);
    chk("unmapped err", 32'h1, e);
    wr(CTRL_ADDR, 8'h7B);
    rdChk("ctrl rw", CTRL_ADDR, 32'h7B);
    $display("register test done");
    for (int k = 0; k < 2; k++) begin
      cfg = {2'h1, k[1:0], 4'h8};
      wr(CTRL_ADDR, cfg);
      wr(CTRL_ADDR, cfg | 8'h04);
      wr(DATA_ADDR, 8'hA5);
      for (cnt = 0; cnt < 400 && spi_link_if_i.sclk !== 1'b1; cnt++)
        @(posedge clk);
      for (cnt = 0; cnt < 400 && spi_link_if_i.sclk === 1'b1; cnt++)
        @(posedge clk);
      chk("half period", 32'h1 << (2 * k), cnt);
      waitRx;
      apb(1'b0, DATA_ADDR, 32'h0);
      wr(CTRL_ADDR, cfg);
      $display("rate %0d test done", k);
    end
    for (int m = 0; m < 4; m++) begin
      rate = (m == 3) ? 2'h3 : 2'h2;
      bitT = 2 << (2 * rate);
      cfg = {2'h1, rate, 2'h2, m[1], m[0]};
      wr(CTRL_ADDR, cfg);
      feMaster <= 1'b0;
      feCpol <= m[0];
      feCpha <= m[1];
      wr(CTRL_ADDR, cfg | 8'h04);
      chk("sclk idle", m[0], spi_link_if_i.sclk);
      feGo(farBytes[m]);
      wr(CTRL_ADDR, (cfg | 8'h04) & 8'hBF);
      wr(DATA_ADDR, devBytes[m]);
      for (cnt = 0; cnt < 400 && spi_link_if_i.sclk === m[0]; cnt++)
        @(posedge clk);
      if (!m[1]) bitT = bitT + bitT / 2;
      chk("start delay", 32'h1, cnt <= bitT + 2);
      waitRx;
      rdChk("master rx", DATA_ADDR, farBytes[m]);
      waitFe;
      chk("far rx", devBytes[m], feGot);
      apb(1'b0, STAT_ADDR, 32'h0);
      chk("rxfull clear", 32'h0, r[STAT_RXFULL]);
      wr(CTRL_ADDR, cfg | 8'h04);
      wr(CTRL_ADDR, cfg);
      $display("master mode %0d done", m);
    end
    for (int m = 0; m < 4; m++) begin
      cfg = {6'h10, m[1], m[0]};
      wr(CTRL_ADDR, cfg);
      feMaster <= 1'b1;
      feCpol <= m[0];
      feCpha <= m[1];
      wr(CTRL_ADDR, cfg | 8'h04);
      wr(DATA_ADDR, devBytes[m]);
      chk("miso idle", 32'h1, spi_link_if_i.devMisoOeB);
      feGo(farBytes[m]);
      waitFe;
      waitRx;
      rdChk("slave rx", DATA_ADDR, farBytes[m]);
      chk("slave tx", devBytes[m], feGot);
      chk("miso freed", 32'h1, spi_link_if_i.devMisoOeB);
      wr(CTRL_ADDR, cfg);
      $display("slave mode %0d done", m);
    end
    wr(CTRL_ADDR, 8'h42);
    feCpol <= 1'b0;
    feCpha <= 1'b1;
    feSelHold <= 1'b1;
    wr(CTRL_ADDR, 8'h46);
    wr(DATA_ADDR, 8'h11);
    feGo(8'h22);
    repeat (40) @(posedge clk);
    wr(DATA_ADDR, 8'h33);
    waitFe;
    chk("held byte", 8'h11, feGot);
    waitRx;
    rdChk("first rx", DATA_ADDR, 8'h22);
    chk("select held", 32'h0, spi_link_if_i.parSelB);
    feSelHold <= 1'b0;
    feGo(8'h44);
    waitFe;
    chk("buffered byte", 8'h33, feGot);
    waitRx;
    rdChk("second rx", DATA_ADDR, 8'h44);
    $display("buffer test done");
    report_and_stop;
  end
endmodule : spi_transfer_format_timing_tb
